/* serial_rx_pkg.sv */
/*
 Shared constants for the asynchronous serial receiver and its controller.
 Assumes a single hclk domain and an external sixteen-times baud tick.
*/
package serial_rx_pkg;
	localparam int OVERSAMPLE    = 16;
	localparam int HALF_BIT      = OVERSAMPLE / 2;
	localparam int DATA_W        = 9;
	localparam int FIFO_DEPTH    = 2;
	localparam logic [3:0] BIT_LAST_TICK  = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] HALF_LAST_TICK = 4'(HALF_BIT - 1);
	localparam logic [3:0] BITS_EIGHT     = 4'h8;
	localparam logic [3:0] BITS_NINE      = 4'h9;
	// Controller register byte offsets
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_DATA   = 4'h8;
	// Control register fields
	localparam int CTRL_PORT_EN = 0;
	localparam int CTRL_CONT_EN = 1;
	localparam int CTRL_CLOCKED = 2;
	localparam int CTRL_NINE    = 3;
	localparam int CTRL_ADDR    = 4;
	localparam int CTRL_RX_IE   = 5;
	localparam int CTRL_PERI_IE = 6;
	localparam int CTRL_GLOB_IE = 7;
	localparam int CTRL_W       = 8;
	// Status register fields
	localparam int STAT_READY   = 0;
	localparam int STAT_FRAME   = 1;
	localparam int STAT_OVERRUN = 2;
	localparam int STAT_NINTH   = 3;
	localparam int STAT_IRQ     = 4;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY    = 2'h0;
endpackage

/* serial_rx_if.sv */
/*
 Interface joining the receiver core and its bus controller.
 Assumes both ends share hclk; the serial pin itself stays outside.
*/
`timescale 1ns/1ps
interface serial_rx_if;
	logic       port_enable;
	logic       continuous_receive_enable;
	logic       clocked_mode;
	logic       nine_bit_receive_select;
	logic       address_detect_enable;
	logic [7:0] rx_data_reg;
	logic       ninth_received_bit;
	logic       framing_error_flag;
	logic       overrun_error_flag;
	logic       receive_ready_flag;
	logic       data_read;
	modport device (
		input  port_enable, continuous_receive_enable, clocked_mode,
		input  nine_bit_receive_select, address_detect_enable, data_read,
		output rx_data_reg, ninth_received_bit, framing_error_flag,
		output overrun_error_flag, receive_ready_flag
	);
	modport ctrl (
		output port_enable, continuous_receive_enable, clocked_mode,
		output nine_bit_receive_select, address_detect_enable, data_read,
		input  rx_data_reg, ninth_received_bit, framing_error_flag,
		input  overrun_error_flag, receive_ready_flag
	);
endinterface

/* serial_rx_core.sv */
/*
 Receiver core: oversampled start detect, majority vote, shift register,
 two-entry character buffer with per-entry framing status, overrun.
 Assumes baud_tick16 is a one-cycle pulse at sixteen times the bit rate
 and that data_read pulses once per software read of the data register.
*/
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module serial_rx_core #(
	parameter int DATA_W     = serial_rx_pkg::DATA_W,
	parameter int FIFO_DEPTH = serial_rx_pkg::FIFO_DEPTH
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic baud_tick16,
	input  wire logic serial_in_pin,
	serial_rx_if.device link
);
	import serial_rx_pkg::*;

	// IDLE hunts for the start edge, START checks mid-start, DATA shifts
	// in the data bits, STOP samples the stop position and hands over
	typedef enum logic [1:0] {IDLE, START, DATA, STOP} rx_state_e;

	rx_state_e             state;
	logic                  pin_meta;
	logic                  pin_sync;
	logic                  pin_prev;
	logic [3:0]            tick_cnt;
	logic [3:0]            bit_cnt;
	logic [2:0]            vote;
	logic [DATA_W-1:0]     rx_shift_reg;
	logic [DATA_W-1:0]     fifo_data [FIFO_DEPTH];
	logic                  fifo_framing_error_flag [FIFO_DEPTH];
	logic                  rd_ptr;
	logic [1:0]            count;
	logic                  overrun;
	logic [7:0]            data_q;
	logic                  ninth_q;
	logic                  framing_error_flag_q;
	logic                  ready_q;

	// Enable decode and bit timing. The shift register is always nine wide;
	// in eight-bit mode the character ends one place high and is realigned,
	// which keeps a single shift path for both character widths.
	wire rx_on      = link.port_enable & link.continuous_receive_enable & ~link.clocked_mode;
	wire port_off   = ~link.port_enable;
	wire [3:0] nbits = link.nine_bit_receive_select ? BITS_NINE : BITS_EIGHT;
	wire bit_end    = baud_tick16 && tick_cnt == BIT_LAST_TICK;
	wire half_end   = baud_tick16 && tick_cnt == HALF_LAST_TICK;
	wire majority   = (vote[0] & vote[1]) | (vote[1] & vote[2]) | (vote[0] & vote[2]);
	wire [DATA_W-1:0] shifted = {majority, rx_shift_reg[DATA_W-1:1]};
	// Eight-bit characters land right-aligned once the stop bit is reached
	wire [DATA_W-1:0] aligned = link.nine_bit_receive_select ? rx_shift_reg
	                            : {1'b0, rx_shift_reg[DATA_W-1:1]};
	wire stop_done  = state == STOP && bit_end;
	wire keep       = ~(link.nine_bit_receive_select & link.address_detect_enable) | aligned[DATA_W-1];
	// A character that address mode discards is neither pushed nor counted
	// as an overrun, so filtered traffic can never stall the receiver
	wire push       = stop_done && keep && !overrun && count != 2'(FIFO_DEPTH);
	wire overflow   = stop_done && keep && !overrun && count == 2'(FIFO_DEPTH);
	wire pop        = link.data_read && count != 2'h0;
	wire wr_idx     = rd_ptr ^ count[0];

	// Two-flop synchroniser; only pin_sync feeds logic
	// pin_prev resets to the idle level, so reset never fakes a start edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
			pin_prev <= 1'b1;
		end else begin
			pin_meta <= serial_in_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Receive state machine; every stage counts oversampling ticks.
	// The start check comes half a bit after the edge and every later
	// sample a whole bit after the one before, so sampling sits near the
	// bit centres. The vote uses the three tick samples just before each
	// data bit centre, so one disturbed sample cannot flip a data bit.
	// Losing the enable or hitting overrun drops any half-received character.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state        <= IDLE;
			tick_cnt     <= 4'h0;
			bit_cnt      <= 4'h0;
			vote         <= 3'h7;
			rx_shift_reg <= '0;
		end else if (!rx_on || overrun) begin
			state    <= IDLE;
			tick_cnt <= 4'h0;
		end else begin
			if (baud_tick16) begin
				tick_cnt <= tick_cnt + 4'h1;
				vote     <= {vote[1:0], pin_sync};
			end
			unique case (state)
				IDLE: if (pin_prev && !pin_sync) begin
					state    <= START;
					tick_cnt <= 4'h0;
				end
				START: if (half_end) begin
					tick_cnt <= 4'h0;
					bit_cnt  <= 4'h0;
					state    <= pin_sync ? IDLE : DATA;
				end
				DATA: if (bit_end) begin
					rx_shift_reg <= shifted;
					bit_cnt      <= bit_cnt + 4'h1;
					tick_cnt     <= 4'h0;
					if (bit_cnt + 4'h1 == nbits) begin
						state <= STOP;
					end
				end
				STOP: if (bit_end) begin
					state    <= IDLE;
					tick_cnt <= 4'h0;
				end
			endcase
		end
	end

	// Character buffer; a push and a pop in one cycle both take effect.
	// Limitation: a character that completes while both entries are full is
	// an overrun even if a read lands in that same cycle, because the slot
	// is only free after the read.
	// Port disable empties the buffer but leaves stored bits in place; they
	// only show through stale data and ninth-bit reads, never through ready or framing.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_ptr  <= 1'b0;
			count   <= 2'h0;
			overrun <= 1'b0;
			for (int i = 0; i < FIFO_DEPTH; i++) begin
				fifo_data[i] <= '0;
				fifo_framing_error_flag[i] <= 1'b0;
			end
		end else if (port_off) begin
			rd_ptr  <= 1'b0;
			count   <= 2'h0;
			overrun <= 1'b0;
		end else begin
			if (push) begin
				fifo_data[wr_idx] <= aligned;
				fifo_framing_error_flag[wr_idx] <= ~pin_sync;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			count <= count + {1'b0, push} - {1'b0, pop};
			// Overrun set wins; only receive disable clears it here
			if (overflow) begin
				overrun <= 1'b1;
			end else if (!link.continuous_receive_enable) begin
				overrun <= 1'b0;
			end
		end
	end

	// Registered view of the oldest entry. Data and ninth bit are not
	// cleared when the buffer empties, so software must test ready first;
	// framing is masked so that an empty buffer never shows an error.
	// One register stage keeps the bus path short at the cost of one cycle
	// between a push and the ready flag.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_q  <= 8'h00;
			ninth_q <= 1'b0;
			framing_error_flag_q  <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			data_q  <= fifo_data[rd_ptr][7:0];
			ninth_q <= fifo_data[rd_ptr][DATA_W-1];
			framing_error_flag_q  <= port_off ? 1'b0 : (count != 2'h0) & fifo_framing_error_flag[rd_ptr];
			ready_q <= rx_on && count != 2'h0;
		end
	end

	// Flags to the controller, all straight from flip-flops
	assign link.rx_data_reg        = data_q;
	assign link.ninth_received_bit = ninth_q;
	assign link.framing_error_flag = framing_error_flag_q;
	assign link.overrun_error_flag = overrun;
	assign link.receive_ready_flag = ready_q;
endmodule // serial_rx_core

/* serial_rx_ctrl.sv */
/*
 AHB-Lite slave controller that drives the receiver's control bits,
 reports its status and pops characters on data register reads.
 Assumes single word transfers; always answers OKAY with no wait states.
*/
`timescale 1ns/1ps
module serial_rx_ctrl (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic      [1:0]  hresp,
	output logic             rx_irq,
	serial_rx_if.ctrl        link
);
	import serial_rx_pkg::*;

	logic [CTRL_W-1:0] ctrl;
	logic              wr_pend;
	logic [3:0]        wr_ofs;
	logic              rd_pulse;
	logic              irq_q;

	// Address phase decode
	wire       take   = hsel && hready && htrans == HTRANS_NONSEQ;
	wire [3:0] ofs    = haddr[3:0];
	wire       rd_dat = take && !hwrite && ofs == OFS_DATA;
	wire [31:0] status = {27'h0, irq_q, link.ninth_received_bit, link.overrun_error_flag,
	                      link.framing_error_flag, link.receive_ready_flag};
	wire       irq_next = link.receive_ready_flag & ctrl[CTRL_RX_IE]
	                      & ctrl[CTRL_PERI_IE] & ctrl[CTRL_GLOB_IE];

	// Bus slave: reads are registered at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl     <= '0;
			wr_pend  <= 1'b0;
			wr_ofs   <= 4'h0;
			hrdata   <= 32'h0;
			rd_pulse <= 1'b0;
			irq_q    <= 1'b0;
		end else begin
			wr_pend  <= take && hwrite;
			wr_ofs   <= ofs;
			rd_pulse <= rd_dat;
			irq_q    <= irq_next;
			if (wr_pend && wr_ofs == OFS_CTRL) begin
				ctrl <= hwdata[CTRL_W-1:0];
			end
			if (take && !hwrite) begin
				unique case (ofs)
					OFS_CTRL:   hrdata <= {24'h0, ctrl};
					OFS_STATUS: hrdata <= status;
					OFS_DATA:   hrdata <= {24'h0, link.rx_data_reg};
					default:    hrdata <= 32'h0;
				endcase
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;
	assign rx_irq    = irq_q;
	assign link.port_enable               = ctrl[CTRL_PORT_EN];
	assign link.continuous_receive_enable = ctrl[CTRL_CONT_EN];
	assign link.clocked_mode              = ctrl[CTRL_CLOCKED];
	assign link.nine_bit_receive_select   = ctrl[CTRL_NINE];
	assign link.address_detect_enable     = ctrl[CTRL_ADDR];
	assign link.data_read                 = rd_pulse;
	wire unused = &{1'b0, hsize, haddr[31:4]};
endmodule // serial_rx_ctrl

/* serial_rx_properties.sv */
/*
 Checks on the receiver link flags.
 Assumes one hclk domain; placed beside the link in the bench.
*/
`timescale 1ns/1ps
module serial_rx_properties (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic port_enable,
	input wire logic continuous_receive_enable,
	input wire logic nine_bit_receive_select,
	input wire logic address_detect_enable,
	input wire logic ninth_received_bit,
	input wire logic framing_error_flag,
	input wire logic overrun_error_flag,
	input wire logic receive_ready_flag
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Four cycles let the clear reach the registered flags
	sequence s_port_off;
		!port_enable [*4];
	endsequence
	sequence s_rx_off;
		!continuous_receive_enable [*2];
	endsequence
	property p_port_empty;
		s_port_off |-> !receive_ready_flag;
	endproperty
	a_port_empty: assert property (p_port_empty)
		else $error("ready with port off");
	property p_port_fe;
		s_port_off |-> !framing_error_flag;
	endproperty
	a_port_fe: assert property (p_port_fe)
		else $error("framing with port off");
	property p_ovr_hold;
		overrun_error_flag && port_enable && continuous_receive_enable |=> overrun_error_flag;
	endproperty
	a_ovr_hold: assert property (p_ovr_hold)
		else $error("overrun dropped");
	property p_ovr_clr;
		s_rx_off |-> !overrun_error_flag;
	endproperty
	a_ovr_clr: assert property (p_ovr_clr)
		else $error("overrun kept");
	property p_ovr_full;
		$rose(overrun_error_flag) |-> receive_ready_flag;
	endproperty
	a_ovr_full: assert property (p_ovr_full)
		else $error("overrun with room");
	property p_ready_src;
		$rose(receive_ready_flag) |-> $past(continuous_receive_enable, 4) && $past(port_enable, 4);
	endproperty
	a_ready_src: assert property (p_ready_src)
		else $error("ready while off");
	property p_addr;
		$rose(receive_ready_flag) && nine_bit_receive_select && address_detect_enable
			|-> ninth_received_bit;
	endproperty
	a_addr: assert property (p_addr)
		else $error("data kept in address mode");
	// Empty buffer shows no framing status
	property p_fe_empty;
		!receive_ready_flag && port_enable && continuous_receive_enable
			&& $past(continuous_receive_enable) |-> !framing_error_flag;
	endproperty
	a_fe_empty: assert property (p_fe_empty)
		else $error("framing with empty buffer");
endmodule // serial_rx_properties

/* tb.sv */
/*
 Bench: AHB-Lite master, serial line driver, queue model.
 Assumes core and controller share hclk.
*/
`timescale 1ns/1ps
module tb;
	import serial_rx_pkg::*;
	localparam int BIT = 4 * OVERSAMPLE;
	logic        hclk, hresetn, hwrite, tick, pin, rx_irq, hreadyout;
	logic [1:0]  htrans, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0]  cfg;
	logic [9:0]  q[$];
	logic        ovr;
	int          n_mismatch = 0, n_checks = 0, cyc = 0;
	serial_rx_if link();
	serial_rx_core u_serial_rx_core (.hclk, .hresetn, .baud_tick16(tick), .serial_in_pin(pin),
		.link(link));
	serial_rx_ctrl u_serial_rx_ctrl (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_irq,
		.link(link));
	serial_rx_properties u_serial_rx_properties (.hclk, .hresetn,
		.port_enable(link.port_enable),
		.continuous_receive_enable(link.continuous_receive_enable),
		.nine_bit_receive_select(link.nine_bit_receive_select),
		.address_detect_enable(link.address_detect_enable),
		.ninth_received_bit(link.ninth_received_bit),
		.framing_error_flag(link.framing_error_flag),
		.overrun_error_flag(link.overrun_error_flag),
		.receive_ready_flag(link.receive_ready_flag));
	initial begin
		hclk = 0;
		forever #12.5 hclk = ~hclk;
	end
	// Tick every fourth cycle, so one bit is 64 cycles
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		tick <= (cyc % 4 == 3);
		if (cyc == 60000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			$display("Error at %0t: got %h exp %h", $time, g, e);
			n_mismatch++;
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		@(posedge hclk);
		htrans <= HTRANS_NONSEQ;
		haddr <= {28'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({30'h0, hresp}, {30'h0, HRESP_OKAY});
	endtask
	// Expected status from the model; ready also needs the receiver on
	task automatic status();
		logic [31:0] e;
		e = 32'h0;
		if (q.size() > 0) begin
			e[STAT_READY] = cfg[CTRL_PORT_EN] & cfg[CTRL_CONT_EN] & ~cfg[CTRL_CLOCKED];
			e[STAT_FRAME] = q[0][9];
			e[STAT_NINTH] = q[0][8];
			e[STAT_IRQ] = e[STAT_READY] & (&cfg[7:5]);
		end
		e[STAT_OVERRUN] = ovr;
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd, e);
		chk({31'h0, rx_irq}, {31'h0, e[STAT_IRQ]});
	endtask
	task automatic pop();
		bus(1'b0, OFS_DATA, 32'h0);
		chk(rd & 32'hff, {24'h0, q[0][7:0]});
		void'(q.pop_front());
		repeat (3) @(posedge hclk);
	endtask
	task automatic setcfg(input logic [7:0] v);
		bus(1'b1, OFS_CTRL, {24'h0, v});
		if (!v[CTRL_PORT_EN]) q.delete();
		if (!v[CTRL_PORT_EN] || !v[CTRL_CONT_EN]) ovr = 1'b0;
		cfg = v;
		repeat (3) @(posedge hclk);
	endtask
	// One frame LSB first, then one idle bit; the model follows
	task automatic send(input logic [8:0] v, input logic stop);
		int n;
		n = cfg[CTRL_NINE] ? 9 : 8;
		pin <= 1'b0;
		repeat (BIT) @(posedge hclk);
		for (int i = 0; i < n; i++) begin
			pin <= v[i];
			repeat (BIT) @(posedge hclk);
		end
		pin <= stop;
		repeat (BIT) @(posedge hclk);
		pin <= 1'b1;
		repeat (BIT) @(posedge hclk);
		if (!(cfg[CTRL_PORT_EN] && cfg[CTRL_CONT_EN] && !cfg[CTRL_CLOCKED])) return;
		if (!cfg[CTRL_NINE]) v[8] = 1'b0;
		if (cfg[CTRL_NINE] && cfg[CTRL_ADDR] && !v[8]) return;
		if (q.size() == FIFO_DEPTH) ovr = 1'b1;
		else if (!ovr) q.push_back({~stop, v});
	endtask
	initial begin
		hresetn = 1'b0;
		pin = 1'b1;
		tick = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		cfg = 8'h0;
		ovr = 1'b0;
		void'($urandom(32'h31fa));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		setcfg(8'he3);
		bus(1'b1, OFS_STATUS, 32'h1f);
		status();
		bus(1'b0, 4'hc, 32'h0);
		chk(rd, 32'h0);
		send(9'($urandom), 1'b1);
		send(9'($urandom), 1'b0);
		status();
		pop();
		status();
		pop();
		// Start pulse shorter than half a bit is dropped
		pin <= 1'b0;
		repeat (HALF_BIT) @(posedge hclk);
		pin <= 1'b1;
		repeat (2 * BIT) @(posedge hclk);
		status();
		for (int i = 0; i < 4; i++) send(9'($urandom), 1'b1);
		status();
		pop();
		pop();
		status();
		setcfg(8'he1);
		setcfg(8'h63);
		status();
		send(9'($urandom), 1'b1);
		status();
		pop();
		setcfg(8'h67);
		send(9'($urandom), 1'b1);
		status();
		setcfg(8'heb);
		send(9'h1a5, 1'b1);
		send(9'h05a, 1'b1);
		status();
		pop();
		status();
		pop();
		setcfg(8'hfb);
		send(9'h033, 1'b1);
		send(9'h1c3, 1'b1);
		status();
		pop();
		setcfg(8'heb);
		send(9'h077, 1'b0);
		status();
		setcfg(8'he9);
		status();
		setcfg(8'hea);
		status();
		test_done();
	end
endmodule // tb
